// ===== logic/ccr_regs.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module ccr_regs
    import ccr_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic SINGLE_MODE,
    input wire logic HARDWARE_TRIGGER_PIN,
    input wire logic ALARM,
    input wire logic FG_CAL_FINISHED,
    input wire logic BG_PHASE_REACHED,
    input wire logic BG_STOP_REQUEST,
    input wire logic CORE_SLEEPING,
    output logic CALIBRATION_STATUS_PIN,
    output logic CAL_RESET,
    output logic DIVIDER_RESET,
    output logic CAL_VALUES_CLEAR,
    output logic FG_RUNNING,
    output logic BG_RUNNING,
    output logic FG_OFFSET_ON,
    output logic BG_OFFSET_ON,
    output logic OFFSET_FILTER_ON,
    output logic CAL_TRIGGER,
    output logic CORE_WAKE,
    output logic CH_A_USES_B,
    output logic CH_B_USES_A
);
    // ==========================================
    // Register storage
    logic [7:0] input_selection; // Input routing
    logic [7:0] calibration_run_control; // Run bit
    logic [7:0] calibration_configuration; // Engine options
    logic [7:0] calibration_pin_setup; // Pin and trigger source
    logic [7:0] software_trigger; // Stand-in for the trigger pin
    logic foreground_complete_flag; // Done status
    logic cal_stopped; // Stopped status
    ccr_state_t state; // Engine state
    ccr_state_t next_state; // Engine next state
    logic [3:0] clr_count; // Value clear timer
    logic run_q; // Run bit one cycle ago
    // ==========================================
    // Address decode
    wire hit_insel = ADDR == CCR_OFS_INSEL;
    wire hit_run = ADDR == CCR_OFS_RUN;
    wire hit_cfg = ADDR == CCR_OFS_CFG;
    wire hit_state = ADDR == CCR_OFS_STATE;
    wire hit_pin = ADDR == CCR_OFS_PIN;
    wire hit_swtrig = ADDR == CCR_OFS_SWTRIG;
    wire run = calibration_run_control[CCR_BIT_RUN];
    wire fg_en = calibration_configuration[CCR_BIT_FG];
    wire bg_en = calibration_configuration[CCR_BIT_BG];
    // Rising edge of run starts a fresh pass with current settings
    wire run_rise = run & ~run_q;
    wire [1:0] status_sel = calibration_pin_setup[2:1];
    wire [7:0] state_word = {6'h00, cal_stopped, foreground_complete_flag};
    // Unmapped addresses read zero
    wire [7:0] read_mux =
        hit_insel ? input_selection :
        hit_run ? calibration_run_control :
        hit_cfg ? calibration_configuration :
        hit_state ? state_word :
        hit_pin ? calibration_pin_setup :
        hit_swtrig ? software_trigger : 8'h00;
    // ==========================================
    // Writable registers; the status word has no write path
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            input_selection <= CCR_RST_INSEL;
            calibration_run_control <= CCR_RST_RUN;
            calibration_configuration <= CCR_RST_CFG;
            calibration_pin_setup <= CCR_RST_PIN;
            software_trigger <= CCR_RST_SWTRIG;
        end
        else if (WR)
        begin
            // Reserved bits are plain storage, as software may expect
            if (hit_insel)
                input_selection <= WDATA;
            if (hit_run)
                calibration_run_control <= WDATA;
            // Taken at any time; software must stop the engine first
            if (hit_cfg)
                calibration_configuration <= WDATA;
            if (hit_pin)
                calibration_pin_setup <= WDATA;
            if (hit_swtrig)
                software_trigger <= WDATA;
            // Writes to the status offset fall through here
        end
    end
    // ==========================================
    // Read data, one cycle after the strobe
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
            RDATA <= 8'h00;
        else
            RDATA <= RD ? read_mux : 8'h00;
    end
    // ==========================================
    // Input routing
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            CH_A_USES_B <= 1'b0;
            CH_B_USES_A <= 1'b0;
        end
        else if (SINGLE_MODE)
        begin
            // Reserved codes keep the previous routing
            if (input_selection[1:0] == CCR_SIN_A)
            begin
                CH_A_USES_B <= 1'b0;
                CH_B_USES_A <= 1'b1;
            end
            else if (input_selection[1:0] == CCR_SIN_B)
            begin
                CH_A_USES_B <= 1'b1;
                CH_B_USES_A <= 1'b0;
            end
        end
        else
        begin
            // Swap bit only matters with two channels
            CH_A_USES_B <= input_selection[CCR_BIT_SWAP];
            CH_B_USES_A <= input_selection[CCR_BIT_SWAP];
        end
    end
    // ==========================================
    // Engine sequencing
    always_comb
    begin
        next_state = state;
        unique case (state)
            CCR_IDLE:
                if (run_rise)
                    next_state = CCR_CLEAR;
            CCR_CLEAR:
                if (clr_count == CCR_CLR_CYCLES)
                    // Skip foreground when its bit is low
                    next_state = fg_en ? CCR_FG :
                        (bg_en ? CCR_BG : CCR_HALT);
            CCR_FG:
                if (FG_CAL_FINISHED)
                    next_state = bg_en ? CCR_BG : CCR_HALT;
            CCR_BG:
                if (BG_STOP_REQUEST & BG_PHASE_REACHED)
                    next_state = CCR_HALT;
            CCR_HALT:
                if (bg_en & ~BG_STOP_REQUEST)
                    next_state = CCR_BG;
        endcase
    end
    // State, clear timer and run history; a low run bit holds reset
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            state <= CCR_IDLE;
            clr_count <= 4'h0;
            run_q <= 1'b0;
        end
        else
        begin
            run_q <= run;
            state <= run ? next_state : CCR_IDLE;
            clr_count <= (state == CCR_CLEAR) ? clr_count + 4'h1 : 4'h0;
        end
    end
    // ==========================================
    // Status flags
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            foreground_complete_flag <= 1'b0;
            cal_stopped <= 1'b0;
        end
        else if (~run)
        begin
            foreground_complete_flag <= 1'b0;
            cal_stopped <= 1'b0;
        end
        else
        begin
            if (state == CCR_FG && FG_CAL_FINISHED)
                foreground_complete_flag <= 1'b1;
            else if (state == CCR_CLEAR)
                foreground_complete_flag <= 1'b0;
            // High while halted, low once calibration runs again
            cal_stopped <= next_state == CCR_HALT;
        end
    end
    // ==========================================
    // Engine controls
    assign CAL_RESET = ~run;
    // Dividers for the digital block and serial link share the hold
    assign DIVIDER_RESET = ~run;
    assign CAL_VALUES_CLEAR = state == CCR_CLEAR;
    assign FG_RUNNING = state == CCR_FG;
    assign BG_RUNNING = state == CCR_BG;
    // Offset options are gated by their parent calibration
    assign FG_OFFSET_ON = FG_RUNNING &
        calibration_configuration[CCR_BIT_FGOS];
    assign BG_OFFSET_ON = BG_RUNNING & bg_en &
        calibration_configuration[CCR_BIT_BGOS];
    assign OFFSET_FILTER_ON = run &
        calibration_configuration[CCR_BIT_OSFILT];
    // Trigger source choice
    assign CAL_TRIGGER = calibration_pin_setup[CCR_BIT_TRIGSRC] ?
        HARDWARE_TRIGGER_PIN : software_trigger[0];
    // A low trigger wakes a sleeping core
    assign CORE_WAKE = CORE_SLEEPING & ~CAL_TRIGGER;
    // Status pin; reserved code drives low
    assign CALIBRATION_STATUS_PIN =
        (status_sel == CCR_SEL_DONE) ? foreground_complete_flag :
        (status_sel == CCR_SEL_ALARM) ? ALARM : 1'b0;
    // ==========================================
    // Checks
    chk_run_holds_reset: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        !run |=> state == CCR_IDLE)
        else $error("engine not held idle");
    chk_rerun_clears: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        run_rise && state == CCR_IDLE |=> state == CCR_CLEAR)
        else $error("rerun did not start");
    chk_fg_skip: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        state == CCR_CLEAR && clr_count == CCR_CLR_CYCLES && !fg_en
        && run |=> state != CCR_FG)
        else $error("foreground not skipped");
    chk_done_sets: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        state == CCR_FG && FG_CAL_FINISHED && run
        |=> foreground_complete_flag)
        else $error("done flag missing");
    chk_stopped_halt: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        state == CCR_HALT |-> cal_stopped)
        else $error("stopped flag wrong");
    chk_pin_low: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        status_sel == CCR_SEL_LOW |-> !CALIBRATION_STATUS_PIN)
        else $error("status pin not low");
    chk_bgos_gate: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        !bg_en |-> !BG_OFFSET_ON)
        else $error("bg offset without bg");
    chk_trig_hw: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        calibration_pin_setup[0] |-> CAL_TRIGGER == HARDWARE_TRIGGER_PIN)
        else $error("trigger source wrong");
    chk_status_ro: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        WR && hit_state && state == CCR_IDLE && !run
        |=> !foreground_complete_flag && !cal_stopped)
        else $error("status took a write");
    // ==========================================
    // Routing, enable, hold, flag and wake checks
    // Dividers are held in the same cycle the run bit drops
    chk_div_on_stop: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        $fell(run) |-> DIVIDER_RESET && CAL_RESET)
        else $error("dividers not held");
    // A fresh pass must not inherit the old done flag
    chk_start_clears: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        state == CCR_CLEAR && run |=> !foreground_complete_flag)
        else $error("done flag survived restart");
    // Foreground offset only while the foreground pass runs
    chk_fgos_gate: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        !FG_RUNNING |-> !FG_OFFSET_ON)
        else $error("fg offset without fg");
    // Filtering belongs to calibration, so it stops with it
    chk_filter_run: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        !run |-> !OFFSET_FILTER_ON)
        else $error("filter on while held");
    // A low selected trigger must reach the wake output
    chk_wake_low: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        CORE_SLEEPING && !CAL_TRIGGER |-> CORE_WAKE)
        else $error("sleeping core not woken");
    // Dual mode follows the swap bit one cycle later
    chk_route_swap: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        !SINGLE_MODE |=>
        CH_A_USES_B == $past(input_selection[CCR_BIT_SWAP]) &&
        CH_B_USES_A == $past(input_selection[CCR_BIT_SWAP]))
        else $error("swap routing wrong");
    // Single mode on input A feeds both channels from A
    chk_route_single: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        SINGLE_MODE && input_selection[1:0] == CCR_SIN_A
        |=> !CH_A_USES_B && CH_B_USES_A)
        else $error("single routing wrong");
endmodule

// ===== logic/ccr_pkg.sv
// How it works
// - Swap bit exchanges inputs in dual mode
// - Single field picks A or B input
// - Run bit low holds calibration reset
// - Run bit low resets clock dividers
// - Setting run bit reruns calibration
// - Bit four enables offset filtering
// - Background offset needs background calibration
// - Foreground offset needs foreground calibration
// - Bit one enables background calibration
// - Start resets values; foreground optional
// - Stopped bit tracks the halt state
// - Foreground done bit sets on completion
// - Status pin selector chooses source
// - Trigger source picks pin or bit
// - Software trigger bit resets high
// - Low trigger wakes sleeping core
package ccr_pkg;
    // ==========================================
    // Register offsets
    localparam logic [7:0] CCR_OFS_INSEL = 8'h60;
    localparam logic [7:0] CCR_OFS_RUN = 8'h61;
    localparam logic [7:0] CCR_OFS_CFG = 8'h62;
    localparam logic [7:0] CCR_OFS_STATE = 8'h6A;
    localparam logic [7:0] CCR_OFS_PIN = 8'h6B;
    localparam logic [7:0] CCR_OFS_SWTRIG = 8'h6C;
    // ==========================================
    // Reset values
    localparam logic [7:0] CCR_RST_INSEL = 8'h01;
    localparam logic [7:0] CCR_RST_RUN = 8'h01;
    localparam logic [7:0] CCR_RST_CFG = 8'h01;
    localparam logic [7:0] CCR_RST_PIN = 8'h00;
    localparam logic [7:0] CCR_RST_SWTRIG = 8'h01;
    // ==========================================
    // Field positions
    localparam int CCR_BIT_SWAP = 4;
    localparam int CCR_BIT_OSFILT = 4;
    localparam int CCR_BIT_BGOS = 3;
    localparam int CCR_BIT_FGOS = 2;
    localparam int CCR_BIT_BG = 1;
    localparam int CCR_BIT_FG = 0;
    localparam int CCR_BIT_RUN = 0;
    localparam int CCR_BIT_TRIGSRC = 0;
    localparam int CCR_BIT_STOPPED = 1;
    localparam int CCR_BIT_DONE = 0;
    // Status pin selector codes
    localparam logic [1:0] CCR_SEL_DONE = 2'h0;
    localparam logic [1:0] CCR_SEL_ALARM = 2'h2;
    localparam logic [1:0] CCR_SEL_LOW = 2'h3;
    // Single input codes
    localparam logic [1:0] CCR_SIN_A = 2'h1;
    localparam logic [1:0] CCR_SIN_B = 2'h2;
    // Clear timer count that ends clearing; the clear phase lasts five cycles
    localparam logic [3:0] CCR_CLR_CYCLES = 4'h4;
    // Engine states
    typedef enum logic [2:0]
    {
        CCR_IDLE,
        CCR_CLEAR,
        CCR_FG,
        CCR_BG,
        CCR_HALT
    } ccr_state_t;
endpackage

// ===== tb/ccr_regs_tb.sv
`timescale 1ns/1ps
module ccr_regs_tb;
    import ccr_pkg::*;
    // ====================
    // Bench signals
    logic CORE_CLK, RST, WR, RD, SINGLE_MODE, HARDWARE_TRIGGER_PIN, ALARM;
    logic FG_CAL_FINISHED, BG_PHASE_REACHED, BG_STOP_REQUEST, CORE_SLEEPING;
    logic [7:0] ADDR, WDATA, RDATA, v;
    logic CALIBRATION_STATUS_PIN, CAL_RESET, DIVIDER_RESET, CAL_VALUES_CLEAR;
    logic FG_RUNNING, BG_RUNNING, FG_OFFSET_ON, BG_OFFSET_ON, OFFSET_FILTER_ON;
    logic CAL_TRIGGER, CORE_WAKE, CH_A_USES_B, CH_B_USES_A;
    logic rd_seen = 1'b0; // Read launched at last edge
    logic saw_clear = 1'b0; // Clear phase spotted since the flag was last cleared
    logic saw_fg = 1'b0; // Foreground pass spotted since the flag was last cleared
    logic exp_bit; // Expected pin level from the stimulus
    logic [7:0] exp_q[$]; // Expected read data, oldest first
    int miscompares = 0;
    int n_checks = 0;
    int seed = 33;
    int i, k;
    ccr_regs dut (.CORE_CLK(CORE_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .SINGLE_MODE(SINGLE_MODE),
        .HARDWARE_TRIGGER_PIN(HARDWARE_TRIGGER_PIN), .ALARM(ALARM),
        .FG_CAL_FINISHED(FG_CAL_FINISHED), .BG_PHASE_REACHED(BG_PHASE_REACHED),
        .BG_STOP_REQUEST(BG_STOP_REQUEST), .CORE_SLEEPING(CORE_SLEEPING),
        .CALIBRATION_STATUS_PIN(CALIBRATION_STATUS_PIN), .CAL_RESET(CAL_RESET),
        .DIVIDER_RESET(DIVIDER_RESET), .CAL_VALUES_CLEAR(CAL_VALUES_CLEAR),
        .FG_RUNNING(FG_RUNNING), .BG_RUNNING(BG_RUNNING),
        .FG_OFFSET_ON(FG_OFFSET_ON), .BG_OFFSET_ON(BG_OFFSET_ON),
        .OFFSET_FILTER_ON(OFFSET_FILTER_ON), .CAL_TRIGGER(CAL_TRIGGER),
        .CORE_WAKE(CORE_WAKE), .CH_A_USES_B(CH_A_USES_B),
        .CH_B_USES_A(CH_B_USES_A));
    // ====================
    // Clock, 5 ns period
    initial
    begin
        CORE_CLK = 1'b0;
        forever #2.5 CORE_CLK = ~CORE_CLK;
    end
    // ====================
    // Checking and bus tasks
    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Pin results reuse the byte compare, zero extended
    task cmp_bit(input logic got, input logic exp);
        cmp_byte({7'h00, got}, {7'h00, exp});
    endtask
    // One-cycle write; a gap cycle follows so strobes never collide
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CORE_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CORE_CLK);
        WR <= 1'b0;
        #1;
    endtask
    // One-cycle read; the watcher compares the answer
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge CORE_CLK);
        ADDR <= a;
        RD <= 1'b1;
        exp_q.push_back(e);
        @(posedge CORE_CLK);
        RD <= 1'b0;
        #1;
    endtask
    // Bounded wait on an engine flag; a hang ends the run
    task wait_run(input logic bg, input logic lvl);
        for (i = 0; i < 40 && (bg ? BG_RUNNING : FG_RUNNING) !== lvl; i++)
        begin
            @(posedge CORE_CLK);
            #1;
        end
        if (i == 40)
        begin
            miscompares++;
            complete_run();
        end
    endtask
    // ====================
    // Read data watcher: answer stands one cycle after the strobe
    always @(posedge CORE_CLK)
        rd_seen <= RD;
    // Engine phases are noted every cycle, not only while waiting
    always @(negedge CORE_CLK)
    begin
        saw_clear <= saw_clear | CAL_VALUES_CLEAR;
        saw_fg <= saw_fg | FG_RUNNING;
        if (rd_seen && exp_q.size() > 0)
            cmp_byte(RDATA, exp_q.pop_front());
    end
    // ====================
    // Main sequence
    initial
    begin
        {RST, WR, RD, ADDR, WDATA, SINGLE_MODE, HARDWARE_TRIGGER_PIN} = '0;
        {ALARM, FG_CAL_FINISHED, BG_PHASE_REACHED, BG_STOP_REQUEST} = '0;
        CORE_SLEEPING = 1'b0;
        RST = 1'b1;
        repeat (6) @(posedge CORE_CLK);
        RST <= 1'b0;
        // Reset values, unmapped place, and status mid-calibration
        rd(CCR_OFS_INSEL, CCR_RST_INSEL);
        rd(CCR_OFS_RUN, CCR_RST_RUN);
        rd(CCR_OFS_CFG, CCR_RST_CFG);
        rd(CCR_OFS_PIN, CCR_RST_PIN);
        rd(CCR_OFS_SWTRIG, CCR_RST_SWTRIG);
        rd(8'h63, 8'h00);
        rd(CCR_OFS_STATE, 8'h00);
        wait_run(1'b0, 1'b1);
        cmp_bit(saw_clear, 1'b1);
        cmp_bit(FG_OFFSET_ON, 1'b0);
        FG_CAL_FINISHED <= 1'b1;
        @(posedge CORE_CLK);
        FG_CAL_FINISHED <= 1'b0;
        rd(CCR_OFS_STATE, 8'h03);
        wr(CCR_OFS_STATE, 8'hFC);
        rd(CCR_OFS_STATE, 8'h03);
        $display("done: reset and foreground pass");
        // Status pin selector, every code, random alarm level
        for (k = 0; k < 4; k++)
        begin
            ALARM <= $random(seed);
            wr(CCR_OFS_PIN, {5'h00, k[1:0], 1'b0});
            exp_bit = (k == 0) || (k == 2 && ALARM);
            cmp_bit(CALIBRATION_STATUS_PIN, exp_bit);
        end
        // Trigger source and wake, all source and soft bit pairs
        CORE_SLEEPING <= 1'b1;
        for (k = 0; k < 4; k++)
        begin
            HARDWARE_TRIGGER_PIN <= $random(seed);
            wr(CCR_OFS_PIN, {7'h00, k[0]});
            wr(CCR_OFS_SWTRIG, {7'h00, k[1]});
            // Expected level comes from what was driven, not the output
            exp_bit = k[0] ? HARDWARE_TRIGGER_PIN : k[1];
            cmp_bit(CAL_TRIGGER, exp_bit);
            cmp_bit(CORE_WAKE, ~exp_bit);
        end
        // An awake core is never woken
        CORE_SLEEPING <= 1'b0;
        @(posedge CORE_CLK);
        #1;
        cmp_bit(CORE_WAKE, 1'b0);
        $display("done: status pin and trigger");
        // Stop calibration: link assumed down first, flags cleared
        wr(CCR_OFS_RUN, 8'h00);
        cmp_bit(CAL_RESET, 1'b1);
        cmp_bit(DIVIDER_RESET, 1'b1);
        rd(CCR_OFS_STATE, 8'h00);
        wr(CCR_OFS_STATE, 8'hFF);
        rd(CCR_OFS_STATE, 8'h00);
        // Enables written while held stay off, random last case
        for (k = 0; k < 4; k++)
        begin
            v = (k == 0) ? 8'h1F : (k == 1) ? 8'h0C : 8'h13;
            if (k == 3)
                v = $random(seed);
            wr(CCR_OFS_CFG, v);
            cmp_bit(FG_OFFSET_ON, 1'b0);
            cmp_bit(BG_OFFSET_ON, 1'b0);
            cmp_bit(OFFSET_FILTER_ON, 1'b0);
            rd(CCR_OFS_CFG, v);
        end
        // Input routing, dual swap off and on, single A and B
        for (k = 0; k < 4; k++)
        begin
            v = (k == 0) ? 8'h01 : (k == 1) ? 8'h12 : (k == 2) ? 8'h11 : 8'h02;
            SINGLE_MODE <= k[1];
            wr(CCR_OFS_INSEL, v);
            @(posedge CORE_CLK);
            #1;
            cmp_bit(CH_A_USES_B, k[1] ? v[1] : v[4]);
            cmp_bit(CH_B_USES_A, k[1] ? v[0] : v[4]);
        end
        $display("done: enables and routing");
        // Rerun with background only: clear, no foreground, halt, resume
        wr(CCR_OFS_CFG, 8'h1A);
        saw_clear = 1'b0;
        saw_fg = 1'b0;
        wr(CCR_OFS_RUN, 8'h01);
        cmp_bit(CAL_RESET, 1'b0);
        wait_run(1'b1, 1'b1);
        cmp_bit(saw_clear, 1'b1);
        cmp_bit(saw_fg, 1'b0);
        cmp_bit(BG_OFFSET_ON, 1'b1);
        cmp_bit(OFFSET_FILTER_ON, 1'b1);
        cmp_bit(FG_OFFSET_ON, 1'b0);
        rd(CCR_OFS_STATE, 8'h00);
        BG_STOP_REQUEST <= 1'b1;
        BG_PHASE_REACHED <= 1'b1;
        wait_run(1'b1, 1'b0);
        cmp_bit(BG_OFFSET_ON, 1'b0);
        rd(CCR_OFS_STATE, 8'h02);
        BG_STOP_REQUEST <= 1'b0;
        wait_run(1'b1, 1'b1);
        rd(CCR_OFS_STATE, 8'h00);
        $display("done: background run");
        // Stop again and rerun foreground with its offset option
        wr(CCR_OFS_RUN, 8'h00);
        wr(CCR_OFS_CFG, 8'h05);
        wr(CCR_OFS_RUN, 8'h01);
        wait_run(1'b0, 1'b1);
        cmp_bit(FG_OFFSET_ON, 1'b1);
        cmp_bit(BG_OFFSET_ON, 1'b0);
        $display("done: foreground offset pass");
        repeat (3) @(posedge CORE_CLK);
        complete_run();
    end
endmodule
